/* verilog/ljcr_pkg.sv */
// Constants and decode functions for the channel jitter config registers
package ljcr_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;

  localparam logic [10:0] CHAN_CFG_OFS = 11'h001;
  localparam logic [10:0] TX_JA_OFS = 11'h002;
  localparam logic [10:0] RX_JA_OFS = 11'h003;
  localparam logic [10:0] SEC_STAT_OFS = 11'h3c0;
  localparam logic [10:0] SEC_CLR_OFS = 11'h3c1;
  localparam logic [10:0] SEC_EN_OFS = 11'h3c2;
  localparam logic [10:0] GLOBAL_CFG_OFS = 11'h3c3;

  localparam int LINE_STD_BIT = 0;
  localparam int SOFT_RST_BIT = 1;
  localparam int SEC_OVF_BIT = 0;
  localparam int SEC_MASK_BIT = 0;
  localparam int JA_BW_BIT = 0;
  localparam int JA_DEPTH_LSB = 1;
  localparam int JA_EN_BIT = 3;
  localparam int JA_LIMIT_BIT = 4;

  localparam logic [7:0] JA_CFG_MASK = 8'h1f;
  localparam logic [7:0] JA_CFG_RST = 8'h00;
  localparam logic [7:0] GLOBAL_CFG_RST = 8'h00;
  localparam logic [7:0] SEC_EN_RST = 8'h00;
  localparam logic LINE_STD_RST = 1'b0;

  localparam int CLK_PERIOD_NS = 40;
  localparam int SOFT_RST_MAX_NS = 1000;
  localparam int SOFT_RST_CYC = (SOFT_RST_MAX_NS / CLK_PERIOD_NS) < 1 ?
    1 : SOFT_RST_MAX_NS / CLK_PERIOD_NS;
  localparam int ONE_SEC_NS = 1_000_000_000;
  localparam int ONE_SEC_CYC = ONE_SEC_NS / CLK_PERIOD_NS;

  localparam logic [7:0] DEPTH_128 = 8'h80;
  localparam logic [7:0] DEPTH_64 = 8'h40;
  localparam logic [7:0] DEPTH_32 = 8'h20;
  localparam logic [7:0] LIMIT_MARGIN = 8'h02;

  localparam logic [12:0] CORNER_T1_WIDE = 13'h1388;
  localparam logic [12:0] CORNER_E1_WIDE = 13'h1a72;
  localparam logic [12:0] CORNER_T1_NARROW = 13'h04ec;
  localparam logic [12:0] CORNER_E1_NARROW = 13'h0366;

  function automatic logic [7:0] ljcr_depth_bits(input logic [1:0] code);
    if (code[1]) begin
      return DEPTH_32;
    end else if (code[0]) begin
      return DEPTH_64;
    end
    return DEPTH_128;
  endfunction

  function automatic logic [12:0] ljcr_corner_mhz(input logic e1,
                                                  input logic narrow);
    if (narrow) begin
      return e1 ? CORNER_E1_NARROW : CORNER_T1_NARROW;
    end
    return e1 ? CORNER_E1_WIDE : CORNER_T1_WIDE;
  endfunction
endpackage

/* verilog/ljcr_ja_if.sv */
// Config byte in, decoded attenuator controls out
`timescale 1ns/1ns
interface ljcr_ja_if;
  logic [7:0] cfg;
  logic lineStd;
  logic bypass;
  logic [7:0] depthBits;
  logic limitEn;
  logic [7:0] nearFull;
  logic [7:0] nearEmpty;
  logic [12:0] cornerMhz;
  modport dec(input cfg, input lineStd, output bypass, output depthBits,
              output limitEn, output nearFull, output nearEmpty,
              output cornerMhz);
  modport user(output cfg, output lineStd, input bypass, input depthBits,
               input limitEn, input nearFull, input nearEmpty,
               input cornerMhz);
endinterface

/* verilog/ljcr_ja_decode.sv */
// Registered decode of one jitter attenuator config byte
`timescale 1ns/1ns
module ljcr_ja_decode
  import ljcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  ljcr_ja_if.dec ja
);
  always_ff @(posedge clk) begin
    if (rst) begin
      ja.bypass <= 1'b1;
      ja.limitEn <= 1'b0;
    end else begin
      ja.bypass <= !ja.cfg[JA_EN_BIT];
      ja.limitEn <= ja.cfg[JA_LIMIT_BIT];
    end
  end

  // Thresholds sit two bits inside each end of the chosen depth
  always_ff @(posedge clk) begin
    if (rst) begin
      ja.depthBits <= DEPTH_128;
      ja.nearFull <= DEPTH_128 - LIMIT_MARGIN;
      ja.nearEmpty <= LIMIT_MARGIN;
    end else begin
      ja.depthBits <= ljcr_depth_bits(ja.cfg[JA_DEPTH_LSB +: 2]);
      ja.nearFull <= ljcr_depth_bits(ja.cfg[JA_DEPTH_LSB +: 2])
                     - LIMIT_MARGIN;
      ja.nearEmpty <= LIMIT_MARGIN;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ja.cornerMhz <= CORNER_T1_WIDE;
    end else begin
      ja.cornerMhz <= ljcr_corner_mhz(ja.lineStd, ja.cfg[JA_BW_BIT]);
    end
  end

  bypass_follow_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> ja.bypass == !$past(ja.cfg[JA_EN_BIT]))
    else $error("bypass does not follow enable bit");

  depth_code_a: assert property (@(posedge clk) disable iff (rst)
    ja.cfg[2:1] == 2'b00 |=> ja.depthBits == 8'h80)
    else $error("depth code 00 not 128 bits");

  limit_margin_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> ja.nearFull + 8'h02 == ja.depthBits && ja.nearEmpty == 8'h02)
    else $error("limit thresholds not two bits from ends");
endmodule

/* verilog/ljcr_regs.sv */
// Per-channel config, soft reset and one-second interrupt register bank
//
// Functional notes
// - A one-second timer overflow sets status bit 0 and raises the irq.
// - Writing one to status bit 0 clears it, and it resets to zero.
// - The overflow irq only asserts while global mask bit 0 is zero.
// - Writing one to the soft reset bit resets this channel, self clearing.
// - Line standard bit 0 picks T1/J1, default, and 1 picks E1.
// - The line standard bit keeps its value through any reset.
// - Each attenuator is bypassed unless its enable bit is one.
// - Depth code 00 gives 128 bits, 01 gives 64, 1X gives 32.
// - With limit enabled the rate adjusts within 2 bits of full or empty.
// - Bandwidth bit picks 5/6.77 Hz at zero or 1.26/0.87 Hz at one.
`timescale 1ns/1ns
module ljcr_regs
  import ljcr_pkg::*;
#(
  parameter int ONE_SEC_CYCLES = ONE_SEC_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdData,
  output logic irq,
  output logic chanSoftReset,
  output logic lineStd,
  output logic txBypass,
  output logic [7:0] txDepthBits,
  output logic txLimitEn,
  output logic [7:0] txNearFull,
  output logic [7:0] txNearEmpty,
  output logic [12:0] txCornerMhz,
  output logic rxBypass,
  output logic [7:0] rxDepthBits,
  output logic rxLimitEn,
  output logic [7:0] rxNearFull,
  output logic [7:0] rxNearEmpty,
  output logic [12:0] rxCornerMhz
);
  localparam int SEC_W = $clog2(ONE_SEC_CYCLES + 1);
  localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(ONE_SEC_CYCLES - 1);
  localparam logic [4:0] SRST_LOAD = 5'(SOFT_RST_CYC);

  logic [7:0] txJaReg;
  logic [7:0] rxJaReg;
  logic secStatReg;
  logic secEnReg;
  logic secMaskReg;
  logic [SEC_W-1:0] secCntReg;
  logic secTick;
  logic [4:0] srstCntReg;
  logic srstBusy;
  logic srstStart;
  logic irqReg;
  logic srstOutReg;
  logic [7:0] rdDataReg;
  logic [7:0] rdValue;
  // Kept out of every reset; the initial value covers power-up only
  logic lineStdReg = LINE_STD_RST;

  logic wrChan;
  logic wrTx;
  logic wrRx;
  logic wrStat;
  logic wrClr;
  logic wrEn;
  logic wrGlob;

  ljcr_ja_if txJa();
  ljcr_ja_if rxJa();

  // Strobe qualified by one register offset, shared by every write decode
  function automatic logic ljcr_addr_hit(input logic strobe,
                                         input logic [ADDR_W-1:0] addr,
                                         input logic [ADDR_W-1:0] ofs);
    return strobe && addr == ofs;
  endfunction

  assign wrChan = ljcr_addr_hit(regWr, regAddr, CHAN_CFG_OFS);
  assign wrTx = ljcr_addr_hit(regWr, regAddr, TX_JA_OFS);
  assign wrRx = ljcr_addr_hit(regWr, regAddr, RX_JA_OFS);
  assign wrStat = ljcr_addr_hit(regWr, regAddr, SEC_STAT_OFS);
  assign wrClr = ljcr_addr_hit(regWr, regAddr, SEC_CLR_OFS);
  assign wrEn = ljcr_addr_hit(regWr, regAddr, SEC_EN_OFS);
  assign wrGlob = ljcr_addr_hit(regWr, regAddr, GLOBAL_CFG_OFS);

  // One-second timer; the count is a parameter so simulation can shorten it
  always_ff @(posedge clk) begin
    if (rst) begin
      secCntReg <= '0;
    end else if (secCntReg == SEC_LAST) begin
      secCntReg <= '0;
    end else begin
      secCntReg <= secCntReg + SEC_W'(1);
    end
  end
  assign secTick = secCntReg == SEC_LAST;

  // Set beats a clear in the same cycle so no overflow is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      secStatReg <= 1'b0;
    end else if (secTick) begin
      secStatReg <= 1'b1;
    end else if ((wrStat || wrClr) && regWrData[SEC_OVF_BIT]) begin
      secStatReg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      secEnReg <= SEC_EN_RST[SEC_OVF_BIT];
    end else if (wrEn) begin
      secEnReg <= regWrData[SEC_OVF_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      secMaskReg <= GLOBAL_CFG_RST[SEC_MASK_BIT];
    end else if (wrGlob) begin
      secMaskReg <= regWrData[SEC_MASK_BIT];
    end
  end

  // Masked status never reaches the pin
  always_ff @(posedge clk) begin
    if (rst) begin
      irqReg <= 1'b0;
    end else begin
      irqReg <= secStatReg && secEnReg && !secMaskReg;
    end
  end

  // Soft reset: a second start while busy is ignored
  assign srstBusy = srstCntReg != 5'h00;
  assign srstStart = wrChan && regWrData[SOFT_RST_BIT] && !srstBusy;

  always_ff @(posedge clk) begin
    if (rst) begin
      srstCntReg <= 5'h00;
    end else if (srstStart) begin
      srstCntReg <= SRST_LOAD;
    end else if (srstBusy) begin
      srstCntReg <= srstCntReg - 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      srstOutReg <= 1'b0;
    end else begin
      srstOutReg <= srstStart || srstCntReg > 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (wrChan) begin
      lineStdReg <= regWrData[LINE_STD_BIT];
    end
  end

  // Soft reset returns the attenuator settings to defaults and holds them
  always_ff @(posedge clk) begin
    if (rst || srstStart || srstBusy) begin
      txJaReg <= JA_CFG_RST;
    end else if (wrTx) begin
      txJaReg <= regWrData & JA_CFG_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || srstStart || srstBusy) begin
      rxJaReg <= JA_CFG_RST;
    end else if (wrRx) begin
      rxJaReg <= regWrData & JA_CFG_MASK;
    end
  end

  always_comb begin
    rdValue = 8'h00;
    case (regAddr)
      CHAN_CFG_OFS: begin
        rdValue[LINE_STD_BIT] = lineStdReg;
        rdValue[SOFT_RST_BIT] = srstBusy;
      end
      TX_JA_OFS: rdValue = txJaReg;
      RX_JA_OFS: rdValue = rxJaReg;
      SEC_STAT_OFS: rdValue[SEC_OVF_BIT] = secStatReg;
      SEC_EN_OFS: rdValue[SEC_OVF_BIT] = secEnReg;
      GLOBAL_CFG_OFS: rdValue[SEC_MASK_BIT] = secMaskReg;
      default: rdValue = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdDataReg <= 8'h00;
    end else if (regRd) begin
      rdDataReg <= rdValue;
    end else begin
      rdDataReg <= 8'h00;
    end
  end

  assign txJa.cfg = txJaReg;
  assign txJa.lineStd = lineStdReg;
  assign rxJa.cfg = rxJaReg;
  assign rxJa.lineStd = lineStdReg;

  ljcr_ja_decode txDec (
    .clk(clk),
    .rst(rst),
    .ja(txJa.dec)
  );

  ljcr_ja_decode rxDec (
    .clk(clk),
    .rst(rst),
    .ja(rxJa.dec)
  );

  assign regRdData = rdDataReg;
  assign irq = irqReg;
  assign chanSoftReset = srstOutReg;
  assign lineStd = lineStdReg;
  assign txBypass = txJa.bypass;
  assign txDepthBits = txJa.depthBits;
  assign txLimitEn = txJa.limitEn;
  assign txNearFull = txJa.nearFull;
  assign txNearEmpty = txJa.nearEmpty;
  assign txCornerMhz = txJa.cornerMhz;
  assign rxBypass = rxJa.bypass;
  assign rxDepthBits = rxJa.depthBits;
  assign rxLimitEn = rxJa.limitEn;
  assign rxNearFull = rxJa.nearFull;
  assign rxNearEmpty = rxJa.nearEmpty;
  assign rxCornerMhz = rxJa.cornerMhz;

  overflow_sets_a: assert property (@(posedge clk) disable iff (rst)
    secTick |=> secStatReg ##1 (irq || !$past(secEnReg)
                               || $past(secMaskReg)))
    else $error("overflow did not set status or irq");

  status_clear_a: assert property (@(posedge clk) disable iff (rst)
    wrStat && regWrData[0] && !secTick |=> !secStatReg)
    else $error("write one did not clear status");

  irq_masked_a: assert property (@(posedge clk) disable iff (rst)
    secMaskReg |=> !irq)
    else $error("irq raised while masked");

  irq_tracks_a: assert property (@(posedge clk) disable iff (rst)
    secStatReg && secEnReg && !secMaskReg |=> irq)
    else $error("enabled unmasked status gave no irq");

  srst_start_a: assert property (@(posedge clk) disable iff (rst)
    srstStart |=> chanSoftReset [*8] ##1 chanSoftReset)
    else $error("soft reset did not hold");

  srst_ends_a: assert property (@(posedge clk) disable iff (rst)
    $rose(chanSoftReset) |-> ##[1:25] !chanSoftReset)
    else $error("soft reset longer than 1 us");

  srst_selfclr_a: assert property (@(posedge clk) disable iff (rst)
    $fell(chanSoftReset) |-> !srstBusy && txJaReg == 8'h00)
    else $error("soft reset bit not cleared");

  line_std_wr_a: assert property (@(posedge clk) disable iff (rst)
    wrChan |=> lineStd == $past(regWrData[0]))
    else $error("line standard not written");

  line_std_keep_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> lineStd == $past(lineStd, 2))
    else $error("line standard changed by reset");

  corner_e1_a: assert property (@(posedge clk) disable iff (rst)
    lineStd && !txJaReg[0] && $stable(lineStd) && $stable(txJaReg)
      |=> txCornerMhz == 13'h1a72)
    else $error("E1 wide corner wrong");

  reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
    regRd && (regAddr == 11'h002 || regAddr == 11'h003)
      |=> regRdData[7:5] == 3'b000)
    else $error("reserved bits read nonzero");

  rd_once_a: assert property (@(posedge clk) disable iff (rst)
    !regRd |=> regRdData == 8'h00)
    else $error("read data stood beyond one cycle");

  clear_reg_a: assert property (@(posedge clk) disable iff (rst)
    wrClr && regWrData[SEC_OVF_BIT] && !secTick |=> !secStatReg)
    else $error("clear register did not clear status");

  irq_off_a: assert property (@(posedge clk) disable iff (rst)
    !secEnReg |=> !irq)
    else $error("irq raised while disabled");

  ja_held_a: assert property (@(posedge clk) disable iff (rst)
    srstBusy |=> txJaReg == 8'h00 && rxJaReg == 8'h00)
    else $error("attenuator config not held during soft reset");

  no_restart_a: assert property (@(posedge clk) disable iff (rst)
    srstBusy && wrChan && regWrData[SOFT_RST_BIT]
      |=> srstCntReg == $past(srstCntReg) - 5'h01)
    else $error("soft reset restarted while busy");

  srst_busy_rd_a: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == CHAN_CFG_OFS && srstBusy |=> regRdData[SOFT_RST_BIT])
    else $error("busy soft reset not shown on read");

  line_std_hold_a: assert property (@(posedge clk)
    !wrChan |=> $stable(lineStd))
    else $error("line standard moved without a write");

  chan_rsvd_a: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == CHAN_CFG_OFS |=> regRdData[7:2] == 6'h00)
    else $error("channel config reserved bits nonzero");

  clr_reads_zero_a: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == SEC_CLR_OFS |=> regRdData == 8'h00)
    else $error("clear register read nonzero");

  tx_bypass_a: assert property (@(posedge clk) disable iff (rst)
    !txJaReg[JA_EN_BIT] |=> txBypass)
    else $error("tx attenuator not bypassed");

  rx_bypass_a: assert property (@(posedge clk) disable iff (rst)
    rxJaReg[JA_EN_BIT] |=> !rxBypass)
    else $error("rx attenuator bypassed while enabled");

  tx_depth_a: assert property (@(posedge clk) disable iff (rst)
    txJaReg[2:1] == 2'b01 |=> txDepthBits == 8'h40)
    else $error("tx depth code 01 not 64 bits");

  rx_depth_a: assert property (@(posedge clk) disable iff (rst)
    rxJaReg[2] |=> rxDepthBits == 8'h20)
    else $error("rx depth code 1X not 32 bits");

  tx_limit_a: assert property (@(posedge clk) disable iff (rst)
    txJaReg[JA_LIMIT_BIT] |=> txLimitEn)
    else $error("tx limit option not enabled");

  rx_corner_a: assert property (@(posedge clk) disable iff (rst)
    !lineStd && rxJaReg[JA_BW_BIT] && $stable(lineStd) && $stable(rxJaReg)
      |=> rxCornerMhz == 13'h04ec)
    else $error("T1 narrow corner wrong");
endmodule

/* dv/ljcr_regs_tb.sv */
// Self-checking bench for the channel config and interrupt register bank
`timescale 1ns/1ns
module ljcr_regs_tb
  import ljcr_pkg::*;
;
  logic clk;
  logic rst;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData;
  logic regWr;
  logic regRd;
  logic [DATA_W-1:0] regRdData;
  logic irq, chanSoftReset, lineStd;
  logic txBypass, txLimitEn, rxBypass, rxLimitEn;
  logic [7:0] txDepthBits, txNearFull, txNearEmpty;
  logic [7:0] rxDepthBits, rxNearFull, rxNearEmpty;
  logic [12:0] txCornerMhz, rxCornerMhz;
  int failures = 0;
  int compares = 0;
  int n;
  logic [7:0] cfgs [4] = '{8'h08, 8'h13, 8'he5, 8'h0e};

  // Short second so the timer fires many times in a short run
  ljcr_regs #(.ONE_SEC_CYCLES(50)) u_ljcr_regs (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq),
    .chanSoftReset(chanSoftReset), .lineStd(lineStd),
    .txBypass(txBypass), .txDepthBits(txDepthBits),
    .txLimitEn(txLimitEn), .txNearFull(txNearFull),
    .txNearEmpty(txNearEmpty), .txCornerMhz(txCornerMhz),
    .rxBypass(rxBypass), .rxDepthBits(rxDepthBits),
    .rxLimitEn(rxLimitEn), .rxNearFull(rxNearFull),
    .rxNearEmpty(rxNearEmpty), .rxCornerMhz(rxCornerMhz));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask

  task automatic chk_ja(input logic tx, input logic [7:0] c,
                        input logic s);
    logic [7:0] d;
    logic [12:0] k;
    d = c[2] ? 8'h20 : (c[1] ? 8'h40 : 8'h80);
    k = c[0] ? (s ? 13'h0366 : 13'h04ec) : (s ? 13'h1a72 : 13'h1388);
    chk(tx ? txBypass : rxBypass, !c[3]);
    chk(tx ? txDepthBits : rxDepthBits, d);
    chk(tx ? txNearFull : rxNearFull, d - 8'h02);
    chk(tx ? txNearEmpty : rxNearEmpty, 8'h02);
    chk(tx ? txLimitEn : rxLimitEn, c[4]);
    chk(tx ? txCornerMhz : rxCornerMhz, k);
  endtask

  task automatic wait_irq(input logic e, input int lim);
    int k;
    k = 0;
    // Step off the edge so an output launched on it has settled
    #1;
    while (irq !== e && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(irq, e);
  endtask

  task automatic done_test(input string name);
    $display("test %s done at %0t", name, $time);
  endtask

  // Whole run is about four hundred cycles; this margin only cuts a hang
  initial begin
    repeat (20000) @(posedge clk);
    $display("[ERR] %0t watchdog expired", $time);
    failures++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    regAddr = '0;
    regWrData = '0;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(CHAN_CFG_OFS, 8'h00);
    rd(TX_JA_OFS, 8'h00);
    rd(RX_JA_OFS, 8'h00);
    rd(SEC_STAT_OFS, 8'h00);
    chk(lineStd, 1'b0);
    chk(irq, 1'b0);
    chk_ja(1'b1, 8'h00, 1'b0);
    chk_ja(1'b0, 8'h00, 1'b0);
    done_test("reset");
    for (int s = 0; s < 2; s++) begin
      wr(CHAN_CFG_OFS, {7'h00, s[0]});
      rd(CHAN_CFG_OFS, {7'h00, s[0]});
      chk(lineStd, s[0]);
      foreach (cfgs[i]) begin
        wr(TX_JA_OFS, cfgs[i]);
        wr(RX_JA_OFS, ~cfgs[i]);
        rd(TX_JA_OFS, cfgs[i] & 8'h1f);
        rd(RX_JA_OFS, ~cfgs[i] & 8'h1f);
        chk_ja(1'b1, cfgs[i], s[0]);
        chk_ja(1'b0, ~cfgs[i], s[0]);
      end
    end
    done_test("attenuator");
    wr(TX_JA_OFS, 8'h1f);
    wr(RX_JA_OFS, 8'h1f);
    wr(CHAN_CFG_OFS, 8'h03);
    #1;
    n = 0;
    while (chanSoftReset === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n[15:0], 16'h0019);
    rd(CHAN_CFG_OFS, 8'h01);
    rd(TX_JA_OFS, 8'h00);
    rd(RX_JA_OFS, 8'h00);
    chk(txBypass, 1'b1);
    // Writes while busy: a second start must not stretch the 25 cycles
    wr(CHAN_CFG_OFS, 8'h03);
    wr(TX_JA_OFS, 8'h1f);
    wr(CHAN_CFG_OFS, 8'h03);
    rd(CHAN_CFG_OFS, 8'h03);
    #1;
    n = 0;
    while (chanSoftReset === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n[15:0], 16'h0013);
    rd(TX_JA_OFS, 8'h00);
    done_test("soft reset");
    // Line standard must survive a full reset
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(CHAN_CFG_OFS, 8'h01);
    chk(lineStd, 1'b1);
    wr(CHAN_CFG_OFS, 8'h00);
    done_test("line standard");
    wr(SEC_EN_OFS, 8'h01);
    wait_irq(1'b1, 120);
    rd(SEC_STAT_OFS, 8'h01);
    wr(SEC_STAT_OFS, 8'h01);
    rd(SEC_STAT_OFS, 8'h00);
    chk(irq, 1'b0);
    wait_irq(1'b1, 120);
    wr(SEC_CLR_OFS, 8'h01);
    rd(SEC_CLR_OFS, 8'h00);
    chk(irq, 1'b0);
    wr(GLOBAL_CFG_OFS, 8'h01);
    n = 0;
    repeat (120) begin
      @(posedge clk);
      #1;
      if (irq !== 1'b0) n++;
    end
    chk(n[15:0], 16'h0000);
    wr(GLOBAL_CFG_OFS, 8'h00);
    wait_irq(1'b1, 60);
    wr(SEC_EN_OFS, 8'h00);
    rd(SEC_STAT_OFS, 8'h01);
    chk(irq, 1'b0);
    done_test("interrupt");
    wr(11'h7ff, 8'hff);
    rd(11'h7ff, 8'h00);
    rd(CHAN_CFG_OFS, 8'h00);
    done_test("unmapped");
    tally_and_finish();
  end
endmodule
